// >>> lfs_deglitch.sv
// one channel off-state deglitch timer
`timescale 1ns/1ps
`default_nettype none
module lfs_deglitch
  import lfs_pkg::*;
#(
  parameter int COUNT = LFS_DEGLITCH_CYCLES,
  parameter int WIDTH = LFS_TIMER_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic gate_on,
  output logic settled
);
  typedef struct packed {
    logic prev_on;
    logic [WIDTH-1:0] count;
    logic done;
  } lfs_dg_state_t;

  lfs_dg_state_t state;
  lfs_dg_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.prev_on = gate_on;
    if (gate_on) begin
      next_state.count = '0;
      next_state.done = 1'b0;
    end else if (state.prev_on) begin
      // fresh turn-off restarts the window
      next_state.count = '0;
      next_state.done = 1'b0;
    end else if (!state.done) begin
      if (state.count == WIDTH'(COUNT - 1)) begin
        next_state.done = 1'b1;
      end else begin
        next_state.count = state.count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign settled = state.done;
endmodule // lfs_deglitch
`default_nettype wire

// >>> lfs_host.sv
// host model: read frames on chip select, pulled-up flag line
`timescale 1ns/1ps
`default_nettype none
module lfs_host (
  input wire logic core_clk,
  input wire logic req,
  input wire logic oe,
  input wire logic fo,
  output logic cs_n = 1'b1,
  output logic fl_n
);
  int n = 0;
  assign fl_n = oe ? fo : 1'b1;  // pull-up when released
  always @(posedge core_clk) begin  // read frame on req
    n <= req ? 10 : (n > 0 ? n - 1 : 0);
    cs_n <= n < 2;
  end
endmodule  // lfs_host
`default_nettype wire

// >>> lfs_pkg.sv
// package: constants for the load fault supervisor
package lfs_pkg;
  localparam int LFS_CHANNELS = 4;
  localparam int LFS_CLK_HZ = 40000000;
  localparam int LFS_DEGLITCH_NS = 60000;
  localparam int LFS_CLK_NS = 25;
  localparam int LFS_DEGLITCH_CYCLES = (LFS_DEGLITCH_NS + LFS_CLK_NS - 1)
                                       / LFS_CLK_NS;
  localparam int LFS_TIMER_W = 12;
  localparam logic [3:0] LFS_FAULT_RESET = 4'h0;
  localparam logic [2:0] LFS_SYNC_RESET = 3'h0;
endpackage : lfs_pkg

// >>> lfs_supervisor.sv
// load fault supervisor: gate gating, open-load detection, fault capture
// Function
// - open-load checked only while gate is off
// - turn-off starts 60 us per-channel deglitch
// - drain below reference after deglitch flags open-load
// - fault word bit n belongs to channel n
// - over-voltage forces all gates off
// - gates resume normally after over-voltage clears
// - over-voltage raises flag, no word bit
// - battery fault suppresses load-fault reporting
// - under-voltage blocks gate turn-on
// - under-voltage raises flag, no word bit
// - under-voltage disables load-fault reporting
// - faults gone before select fall vanish
// - select fall releases flag if faults gone
// - strap chooses internal or external reference
// - select fall captures per-channel fault status
// - select rise clears fault register
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int CHANNELS = LFS_CHANNELS,
  parameter int DEGLITCH_CYCLES = LFS_DEGLITCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [CHANNELS-1:0] gate_command,
  input wire logic [CHANNELS-1:0] drain_below_int_ref,
  input wire logic [CHANNELS-1:0] drain_below_ext_ref,
  input wire logic ext_ref_select,
  input wire logic bat_over_voltage,
  input wire logic bat_under_voltage,
  input wire logic chip_select_n,
  output logic [CHANNELS-1:0] gate_drive,
  output logic [CHANNELS-1:0] fault_word,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe
);
  // pin inputs except gate_command pass three flops; sync[0] feeds only sync[1]
  typedef struct packed {
    logic [CHANNELS-1:0][2:0] drain_sync;
    logic [2:0] ovp_sync;
    logic [2:0] uvp_sync;
    logic [2:0] cs_sync;
    logic [2:0] ref_sync;
    logic [CHANNELS-1:0] drain_low;
    logic ovp;
    logic uvp;
    logic cs_n;
    logic ref_ext;
    logic strap_taken;
    logic [1:0] strap_wait;
    logic [CHANNELS-1:0] fault_reg;
    logic flag;
    logic [CHANNELS-1:0] gate;
  } lfs_state_t;

  lfs_state_t state;
  lfs_state_t next_state;
  logic [CHANNELS-1:0] settled;
  logic [CHANNELS-1:0] drain_sel;

  // agreement of the two later flops counts as a change
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  function automatic logic ext_ref_select_mux(input logic ext,
                                              input logic a,
                                              input logic b);
    ext_ref_select_mux = ext ? b : a;
  endfunction

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      // comparator output picked per strap
      assign drain_sel[g] = ext_ref_select_mux(state.ref_ext,
                              drain_below_int_ref[g], drain_below_ext_ref[g]);
      lfs_deglitch #(
        .COUNT(DEGLITCH_CYCLES),
        .WIDTH(LFS_TIMER_W)
      ) u_dg (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .gate_on(state.gate[g]),
        .settled(settled[g])
      );
    end
  endgenerate

  logic bat_fault;
  logic [CHANNELS-1:0] load_fault;
  logic cs_fall;
  logic cs_rise;

  always_comb begin
    next_state = state;
    bat_fault = state.ovp | state.uvp;
    // off and past deglitch, drain low, no battery fault
    load_fault = ~state.gate & settled & state.drain_low
                 & {CHANNELS{~bat_fault}};
    cs_fall = state.cs_n & ~filt(state.cs_sync, state.cs_n);
    cs_rise = ~state.cs_n & filt(state.cs_sync, state.cs_n);

    for (int i = 0; i < CHANNELS; i++) begin
      next_state.drain_sync[i] = {state.drain_sync[i][1:0], drain_sel[i]};
      next_state.drain_low[i] = filt(state.drain_sync[i],
                                     state.drain_low[i]);
    end
    next_state.ovp_sync = {state.ovp_sync[1:0], bat_over_voltage};
    next_state.uvp_sync = {state.uvp_sync[1:0], bat_under_voltage};
    next_state.cs_sync = {state.cs_sync[1:0], chip_select_n};
    next_state.ref_sync = {state.ref_sync[1:0], ext_ref_select};
    next_state.ovp = filt(state.ovp_sync, state.ovp);
    next_state.uvp = filt(state.uvp_sync, state.uvp);
    next_state.cs_n = filt(state.cs_sync, state.cs_n);

    // strap caught once after reset release, when synchroniser has filled;
    // the reset zeros in the flops must not be mistaken for the strap
    if (!state.strap_taken) begin
      if (state.strap_wait != 2'h3) begin
        next_state.strap_wait = state.strap_wait + 2'h1;
      end else if (state.ref_sync[1] == state.ref_sync[2]) begin
        next_state.ref_ext = state.ref_sync[2];
        next_state.strap_taken = 1'b1;
      end
    end

    // over-voltage forces off, under-voltage blocks on; both self-clear
    if (state.ovp) begin
      next_state.gate = '0;
    end else if (state.uvp) begin
      next_state.gate = state.gate & gate_command;
    end else begin
      next_state.gate = gate_command;
    end

    // capture at select fall only; clear at rise
    if (cs_fall) begin
      next_state.fault_reg = load_fault;
    end else if (cs_rise) begin
      next_state.fault_reg = LFS_FAULT_RESET;
    end

    // battery faults light the flag without touching the word
    if (bat_fault || (|load_fault)) begin
      next_state.flag = 1'b1;
    end else if (cs_fall) begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.cs_sync <= 3'h7;
      state.cs_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign gate_drive = state.gate;
  assign fault_word = state.fault_reg;
  // open drain: only ever pulls low
  assign fault_flag_n_out = 1'b0;
  assign fault_flag_n_oe = state.flag;
endmodule // lfs_supervisor
`default_nettype wire

// >>> lfs_supervisor_assertions.sv
// checker: port assertions for the load fault supervisor
`timescale 1ns/1ps
`default_nettype none
module lfs_sup_assertions
  import lfs_pkg::*;
#(parameter int CHANNELS = LFS_CHANNELS) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [CHANNELS-1:0] gate_command,
  input wire logic bat_over_voltage,
  input wire logic bat_under_voltage,
  input wire logic chip_select_n,
  input wire logic [CHANNELS-1:0] gate_drive,
  input wire logic [CHANNELS-1:0] fault_word,
  input wire logic fault_flag_n_oe
);
  logic [5:0] cs_h;
  logic cs_low;
  // select low 3 to 6 edges back covers the input synchroniser slack
  assign cs_low = !(&cs_h[5:2]);
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) cs_h <= 6'h3F;
    else cs_h <= {cs_h[4:0], chip_select_n};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_ovo; bat_over_voltage [*6] |-> gate_drive == '0; endproperty
  a_ovo: assert property (p_ovo) else $error("gate on in ov");
  property p_uvb;
    bat_under_voltage [*6] |-> !(gate_drive & ~$past(gate_drive));
  endproperty
  a_uvb: assert property (p_uvb) else $error("turn-on in uv");
  property p_run;
    (!bat_over_voltage && !bat_under_voltage) [*6]
      |=> gate_drive == $past(gate_command);
  endproperty
  a_run: assert property (p_run) else $error("gate not following");
  property p_bat;
    (bat_over_voltage || bat_under_voltage) [*6] |-> fault_flag_n_oe;
  endproperty
  a_bat: assert property (p_bat) else $error("no battery flag");
  property p_rel; $fell(fault_flag_n_oe) |-> cs_low; endproperty
  a_rel: assert property (p_rel) else $error("flag released early");
  property p_cap; $changed(fault_word) && fault_word != '0 |-> cs_low; endproperty
  a_cap: assert property (p_cap) else $error("capture off cs");
  property p_clr; chip_select_n [*8] |-> fault_word == '0; endproperty
  a_clr: assert property (p_clr) else $error("word not cleared");
  property p_rst;
    disable iff (1'b0) !reset_n |-> !fault_flag_n_oe && gate_drive == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule  // lfs_sup_assertions
bind lfs_supervisor lfs_sup_assertions #(.CHANNELS(CHANNELS)) chk_u (.*);
`default_nettype wire

// >>> tb_top.sv
// testbench: directed checks of the load fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, reset_n, ov, uv, sel, req, cs_n, fl_n, fo, oe;
  logic [3:0] cmd, d, gd, word, fl;
  int err_total = 0;
  int samples_checked = 0;
  assign fl = {3'h0, !fl_n};
  lfs_supervisor #(.DEGLITCH_CYCLES(20)) dut_u (.core_clk(core_clk),
    .reset_n(reset_n), .gate_command(cmd), .ext_ref_select(sel),
    .drain_below_int_ref(sel ? 4'h0 : d), .drain_below_ext_ref(sel ? d : 4'h0),
    .bat_over_voltage(ov), .bat_under_voltage(uv), .chip_select_n(cs_n),
    .gate_drive(gd), .fault_word(word), .fault_flag_n_out(fo),
    .fault_flag_n_oe(oe));
  lfs_host host_u (.core_clk(core_clk), .req(req), .oe(oe), .fo(fo),
    .cs_n(cs_n), .fl_n(fl_n));
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [3:0] e);
    req = 1;
    w(1);
    req = 0;
    w(8);
    chk(word, e);
    w(10);
    chk(word, 4'h0);
  endtask
  task test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin  // cut a hang short
    #50000;
    err_total++;
    test_done;
  end
  initial begin
    {reset_n, ov, uv, sel, req, cmd, d} = '0;
    for (int s = 0; s < 2; s++) begin  // both strap settings
      reset_n = 0;
      sel = s;
      cmd = 4'h0;
      w(20);
      chk(gd, 4'h0);
      chk(fl, 4'h0);
      reset_n = 1;
      cmd = 4'hF;
      d = 4'hF;
      w(8);
      chk(fl, 4'h0);
      cmd = ~(4'h1 << 2 * s);
      w(12);
      chk(fl, 4'h0);
      w(20);
      chk(fl, 4'h1);
      rd(4'h1 << 2 * s);
      d = 4'h0;
      w(6);
      rd(4'h0);
      chk(fl, 4'h0);
    end
    cmd = 4'hF;
    ov = 1;
    d = 4'hF;
    w(30);
    chk(gd, 4'h0);
    rd(4'h0);
    ov = 0;
    d = 4'h0;
    w(8);
    chk(gd, 4'hF);
    cmd = 4'h0;
    uv = 1;
    w(30);
    cmd = 4'hF;
    d = 4'hF;
    w(30);
    chk(gd, 4'h0);
    rd(4'h0);
    chk(fl, 4'h1);
    test_done;
  end
endmodule  // tb_top
`default_nettype wire
